// ===== ptssc_pkg.sv
// Constants and carrier types of the PWM timer stop/clear and sync control block
package ptssc_pkg;

  localparam int unsigned N_CH     = 4;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_STOP_CLEAR_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] OFF_CHANNEL_WRITE_DISABLE    = 8'h04;
  localparam logic [7:0] OFF_SYNC_CLEAR_SELECT        = 8'h08;
  localparam logic [7:0] OFF_EXT_TRIGGER_FILTER_CTRL  = 8'h0C;
  localparam logic [7:0] OFF_BUFFER_DISABLE_CTRL      = 8'h10;
  localparam logic [7:0] OFF_HW_STOP_CLEAR_ENABLE     = 8'h14;

  // Field widths and positions
  localparam int unsigned SRC_SEL_W      = 4;
  localparam int unsigned SYNC_SEL_W     = 4;
  localparam int unsigned BUF_DIS_W      = 4;
  localparam int unsigned FLT_CLK_LSB    = 4;
  localparam int unsigned FLT_ON_BIT     = 6;
  localparam int unsigned FLT_LEVEL_BIT  = 7;
  localparam int unsigned STOP_EN_LSB    = 0;
  localparam int unsigned CLEAR_EN_LSB   = 8;

  // Reset values
  localparam logic [15:0] RST_SRC_SEL  = 16'h0000;
  localparam logic [15:0] RST_SYNC_SEL = 16'h3210;
  localparam logic [3:0]  RST_WR_BLK   = 4'h0;
  localparam logic [15:0] RST_BUF_DIS  = 16'h0000;
  localparam logic [1:0]  RST_FLT_CLK  = 2'h0;

  // Filter: equal samples needed before the output follows
  localparam int unsigned FLT_SAMPLES = 3;

  // Stop/clear source codes
  localparam logic [3:0] SRC_CMP0 = 4'h0;
  localparam logic [3:0] SRC_CMP1 = 4'h1;
  localparam logic [3:0] SRC_CMP2 = 4'h4;
  localparam logic [3:0] SRC_CMP3 = 4'h5;
  localparam logic [3:0] SRC_IO_A = 4'h8;
  localparam logic [3:0] SRC_IO_B = 4'h9;
  localparam logic [3:0] SRC_OC_A = 4'hA;
  localparam logic [3:0] SRC_OC_B = 4'hB;
  localparam logic [3:0] SRC_TRIG = 4'hC;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ptssc_bus_req_t;

  typedef struct packed {
    logic [3:0] cmp;
    logic       io_a;
    logic       io_b;
    logic       oc_a;
    logic       oc_b;
    logic       trig;
  } ptssc_src_in_t;

endpackage

// ===== ptssc_top.sv
// PWM timer stop/clear source select, sync clear, write disable, trigger filter and buffer disable
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module ptssc_top (
  // Clock, reset, enable
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_clk_en,
  // Register port
  input  wire ptssc_pkg::ptssc_bus_req_t i_bus,
  output logic [ptssc_pkg::DATA_W-1:0] o_rdata,
  // Stop/clear sources
  input  wire ptssc_pkg::ptssc_src_in_t  i_src,
  // Channel controls
  output logic [ptssc_pkg::N_CH-1:0]  o_ch_stop,
  output logic [ptssc_pkg::N_CH-1:0]  o_ch_clear,
  output logic [ptssc_pkg::N_CH-1:0]  o_ch_write_block,
  output logic [15:0]                 o_buf_disable
);
  import ptssc_pkg::*;

  typedef struct packed {
    logic [15:0]       src_sel;
    logic [15:0]       sync_sel;
    logic [N_CH-1:0]   wr_blk;
    logic [15:0]       buf_dis;
    logic [1:0]        flt_clk;
    logic              flt_on;
    logic [N_CH-1:0]   stop_en;
    logic [N_CH-1:0]   clr_en;
    logic [N_CH-1:0]   evt_prev;
    logic [5:0]        div_cnt;
    logic [FLT_SAMPLES-1:0] flt_hist;
    logic              flt_out;
    logic [N_CH-1:0]   stop;
    logic [N_CH-1:0]   clr;
    logic [DATA_W-1:0] rdata;
  } ptssc_state_t;

  ptssc_state_t s_q;
  ptssc_state_t s_d;

  logic              trig_used;
  logic [N_CH-1:0]   raw_src;
  logic [N_CH-1:0]   fire;
  logic [N_CH-1:0]   own_clr;
  logic [N_CH-1:0]   clr_req;
  logic [6:0]        div_top;
  logic              flt_tick;

  // Source multiplexer shared by all channels
  function automatic logic pick_src(input logic [3:0] code, input logic no_oc,
                                    input ptssc_src_in_t src, input logic trg);
    logic r;
    r = 1'b0;
    case (code)
      SRC_CMP0: r = src.cmp[0];
      SRC_CMP1: r = src.cmp[1];
      SRC_CMP2: r = src.cmp[2];
      SRC_CMP3: r = src.cmp[3];
      SRC_IO_A: r = src.io_a;
      SRC_IO_B: r = src.io_b;
      SRC_OC_A: r = no_oc ? 1'b0 : src.oc_a;
      SRC_OC_B: r = no_oc ? 1'b0 : src.oc_b;
      SRC_TRIG: r = trg;
      default:  r = 1'b0;
    endcase
    return r;
  endfunction

  // Filter sample rate: clock divided by 1, 4, 16 or 64
  assign div_top   = 7'h01 << {s_q.flt_clk, 1'b0};
  assign flt_tick  = (s_q.div_cnt == 6'(div_top - 7'h01));
  assign trig_used = s_q.flt_on ? s_q.flt_out : i_src.trig;

  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      assign raw_src[g] = pick_src(s_q.src_sel[g*SRC_SEL_W +: SRC_SEL_W], (g == N_CH-1), i_src,
                                   trig_used);
      assign fire[g]    = raw_src[g] & ~s_q.evt_prev[g];
      assign own_clr[g] = fire[g] & s_q.clr_en[g];
      // Field equal to own index means no sync clear
      assign clr_req[g] = own_clr[g] |
                          ((s_q.sync_sel[g*SYNC_SEL_W +: 2] != 2'(g)) &
                           own_clr[s_q.sync_sel[g*SYNC_SEL_W +: 2]]);
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    // Hardware event edges
    s_d.evt_prev = raw_src;
    s_d.stop     = fire & s_q.stop_en;
    s_d.clr      = clr_req;

    // Trigger noise filter
    if (flt_tick) begin
      s_d.div_cnt  = 6'h00;
      s_d.flt_hist = {s_q.flt_hist[FLT_SAMPLES-2:0], i_src.trig};
    end else begin
      s_d.div_cnt = s_q.div_cnt + 6'h01;
    end
    if (&s_q.flt_hist) begin
      s_d.flt_out = 1'b1;
    end else if (~|s_q.flt_hist) begin
      s_d.flt_out = 1'b0;
    end

    // Register writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        OFF_STOP_CLEAR_SOURCE_SELECT: s_d.src_sel  = i_bus.wdata;
        OFF_CHANNEL_WRITE_DISABLE:    s_d.wr_blk   = i_bus.wdata[N_CH-1:0];
        OFF_SYNC_CLEAR_SELECT: begin
          for (int c = 0; c < N_CH; c++) begin
            s_d.sync_sel[c*SYNC_SEL_W +: SYNC_SEL_W] = {2'b00, i_bus.wdata[c*SYNC_SEL_W +: 2]};
          end
        end
        OFF_EXT_TRIGGER_FILTER_CTRL: begin
          s_d.flt_clk = i_bus.wdata[FLT_CLK_LSB +: 2];
          s_d.flt_on  = i_bus.wdata[FLT_ON_BIT];
          s_d.div_cnt = 6'h00;
        end
        OFF_BUFFER_DISABLE_CTRL: s_d.buf_dis = i_bus.wdata;
        OFF_HW_STOP_CLEAR_ENABLE: begin
          for (int c = 0; c < N_CH; c++) begin
            if (!s_q.wr_blk[c]) begin
              s_d.stop_en[c] = i_bus.wdata[STOP_EN_LSB + c];
              s_d.clr_en[c]  = i_bus.wdata[CLEAR_EN_LSB + c];
            end
          end
        end
        default: ;
      endcase
    end

    // Read data in the following cycle only
    s_d.rdata = '0;
    if (i_bus.rd) begin
      case (i_bus.addr)
        OFF_STOP_CLEAR_SOURCE_SELECT: s_d.rdata = s_q.src_sel;
        OFF_CHANNEL_WRITE_DISABLE:    s_d.rdata = {12'h000, s_q.wr_blk};
        OFF_SYNC_CLEAR_SELECT:        s_d.rdata = s_q.sync_sel;
        OFF_EXT_TRIGGER_FILTER_CTRL: begin
          // Old edge flag bits 1:0 read as zero
          s_d.rdata[FLT_CLK_LSB +: 2] = s_q.flt_clk;
          s_d.rdata[FLT_ON_BIT]       = s_q.flt_on;
          s_d.rdata[FLT_LEVEL_BIT]    = trig_used;
        end
        OFF_BUFFER_DISABLE_CTRL:      s_d.rdata = s_q.buf_dis;
        OFF_HW_STOP_CLEAR_ENABLE: begin
          s_d.rdata[STOP_EN_LSB +: N_CH]  = s_q.stop_en;
          s_d.rdata[CLEAR_EN_LSB +: N_CH] = s_q.clr_en;
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_q          <= '0;
      s_q.src_sel  <= RST_SRC_SEL;
      s_q.sync_sel <= RST_SYNC_SEL;
      s_q.wr_blk   <= RST_WR_BLK;
      s_q.buf_dis  <= RST_BUF_DIS;
      s_q.flt_clk  <= RST_FLT_CLK;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_rdata          = s_q.rdata;
  assign o_ch_stop        = s_q.stop;
  assign o_ch_clear       = s_q.clr;
  assign o_ch_write_block = s_q.wr_blk;
  assign o_buf_disable    = s_q.buf_dis;

  // Checks
  chk_cmp0_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[3:0] == 4'h0 && i_src.cmp[0] && !s_q.evt_prev[0] && s_q.stop_en[0])
    |=> o_ch_stop[0])
    else $error("comparator 0 event did not stop channel 0");

  chk_pin_a_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[7:4] == 4'h8 && i_src.io_a && !s_q.evt_prev[1] && s_q.stop_en[1])
    |=> o_ch_stop[1])
    else $error("pin A event did not stop channel 1");

  chk_oc_b_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[11:8] == 4'hB && i_src.oc_b && !s_q.evt_prev[2] && s_q.stop_en[2])
    |=> o_ch_stop[2])
    else $error("compare output B did not stop channel 2");

  chk_ch3_no_oc: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (s_q.src_sel[15:13] == 3'b101) |-> !raw_src[3])
    else $error("channel 3 took a compare output source");

  chk_trig_src: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (s_q.src_sel[3:0] == 4'hC) |-> (raw_src[0] == trig_used))
    else $error("trigger code did not select the trigger");

  chk_filter_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !s_q.flt_on |-> (trig_used == i_src.trig))
    else $error("filter applied while disabled");

  chk_filter_on: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (s_q.flt_on && $past(s_q.flt_on) && $changed(trig_used)) |-> (s_q.flt_out == $past(s_q.flt_hist[0])))
    else $error("filtered trigger changed without agreeing samples");

  chk_write_block: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_bus.wr && i_bus.addr == OFF_HW_STOP_CLEAR_ENABLE && s_q.wr_blk[0])
    |=> $stable(s_q.stop_en[0]) && $stable(s_q.clr_en[0]))
    else $error("blocked channel 0 accepted a write");

  chk_sync_ch0: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.sync_sel[1:0] == 2'b01 && own_clr[1]) |=> o_ch_clear[0])
    else $error("channel 0 missed sync clear from channel 1");

  chk_sync_none: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.sync_sel[13:12] == 2'b11 && !own_clr[3]) |=> !o_ch_clear[3])
    else $error("channel 3 cleared with sync off");

  chk_buf_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_bus.wr && i_bus.addr == OFF_BUFFER_DISABLE_CTRL)
    |=> (o_buf_disable == $past(i_bus.wdata)))
    else $error("buffer disable write lost");

  chk_read_src: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_bus.rd && !i_bus.wr && i_bus.addr == OFF_STOP_CLEAR_SOURCE_SELECT)
    |=> (o_rdata == $past(s_q.src_sel)))
    else $error("selector read back wrong");

  chk_cmp1_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[3:0] == SRC_CMP1 && i_src.cmp[1] && !s_q.evt_prev[0] && s_q.stop_en[0])
    |=> o_ch_stop[0])
    else $error("comparator 1 event did not stop channel 0");

  chk_cmp2_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[7:4] == SRC_CMP2 && i_src.cmp[2] && !s_q.evt_prev[1] && s_q.stop_en[1])
    |=> o_ch_stop[1])
    else $error("comparator 2 event did not stop channel 1");

  chk_cmp3_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[15:12] == SRC_CMP3 && i_src.cmp[3] && !s_q.evt_prev[3] && s_q.stop_en[3])
    |=> o_ch_stop[3])
    else $error("comparator 3 event did not stop channel 3");

  chk_pin_b_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[15:12] == SRC_IO_B && i_src.io_b && !s_q.evt_prev[3] && s_q.stop_en[3])
    |=> o_ch_stop[3])
    else $error("pin B event did not stop channel 3");

  chk_oc_a_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[3:0] == SRC_OC_A && i_src.oc_a && !s_q.evt_prev[0] && s_q.stop_en[0])
    |=> o_ch_stop[0])
    else $error("compare output A did not stop channel 0");

  chk_trig_stop: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.src_sel[11:8] == SRC_TRIG && trig_used && !s_q.evt_prev[2] && s_q.stop_en[2])
    |=> o_ch_stop[2])
    else $error("trigger event did not stop channel 2");

  chk_own_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && raw_src[1] && !s_q.evt_prev[1] && s_q.clr_en[1])
    |=> o_ch_clear[1])
    else $error("channel 1 event did not clear channel 1");

  chk_stop_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !(|fire)) |=> (o_ch_stop == '0))
    else $error("stop pulse without a source edge");

  chk_stop_gated: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && !s_q.stop_en[0]) |=> !o_ch_stop[0])
    else $error("channel 0 stopped with stop disabled");

  chk_sync_ch1: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.sync_sel[5:4] == 2'b00 && own_clr[0]) |=> o_ch_clear[1])
    else $error("channel 1 missed sync clear from channel 0");

  chk_sync_ch2: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.sync_sel[9:8] == 2'b11 && own_clr[3]) |=> o_ch_clear[2])
    else $error("channel 2 missed sync clear from channel 3");

  chk_sync_ch3: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.sync_sel[13:12] == 2'b10 && own_clr[2]) |=> o_ch_clear[3])
    else $error("channel 3 missed sync clear from channel 2");

  chk_sync_off0: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && s_q.sync_sel[1:0] == 2'b00 && !own_clr[0]) |=> !o_ch_clear[0])
    else $error("channel 0 cleared with sync off");

  chk_block_out: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_bus.wr && i_bus.addr == OFF_CHANNEL_WRITE_DISABLE)
    |=> (o_ch_write_block == $past(i_bus.wdata[N_CH-1:0])))
    else $error("write disable bits not taken");

  chk_write_open: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_bus.wr && i_bus.addr == OFF_HW_STOP_CLEAR_ENABLE && !s_q.wr_blk[2])
    |=> (s_q.stop_en[2] == $past(i_bus.wdata[STOP_EN_LSB + 2])))
    else $error("open channel 2 lost an enable write");

  chk_flag_bits: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_bus.rd && i_bus.addr == OFF_EXT_TRIGGER_FILTER_CTRL) |=> (o_rdata[1:0] == 2'b00))
    else $error("reserved trigger flag bits read nonzero");

  chk_filter_cfg: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_bus.wr && i_bus.addr == OFF_EXT_TRIGGER_FILTER_CTRL)
    |=> (s_q.flt_on == $past(i_bus.wdata[FLT_ON_BIT])))
    else $error("filter enable write lost");

  chk_buf_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_clk_en && i_bus.rd && i_bus.addr == OFF_BUFFER_DISABLE_CTRL)
    |=> (o_rdata == $past(s_q.buf_dis)))
    else $error("buffer disable read back wrong");

endmodule

`default_nettype wire

// ===== ptssc_src_model.sv
// Model of the comparators, pins A and B, compare outputs A and B and trigger pin
`timescale 1ns/100ps
`default_nettype none
module ptssc_src_model (
  // Clock and command from the bench
  input  wire logic                    i_core_clk,
  input  wire logic                    i_fire,
  input  wire logic [3:0]              i_code,
  input  wire logic [3:0]              i_len,
  // Source levels
  output ptssc_pkg::ptssc_src_in_t     o_src
);
  import ptssc_pkg::*;
  logic [3:0] cnt_q  = 4'h0;
  logic [3:0] code_q = 4'h0;
  always @(posedge i_core_clk) begin
    if (i_fire) begin
      cnt_q  <= i_len;
      code_q <= i_code;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // Chosen source high for the hold count, all low otherwise
  always_comb begin
    o_src = '0;
    if (cnt_q != 4'h0) begin
      case (code_q)
        SRC_CMP0: o_src.cmp[0] = 1'b1;
        SRC_CMP1: o_src.cmp[1] = 1'b1;
        SRC_CMP2: o_src.cmp[2] = 1'b1;
        SRC_CMP3: o_src.cmp[3] = 1'b1;
        SRC_IO_A: o_src.io_a = 1'b1;
        SRC_IO_B: o_src.io_b = 1'b1;
        SRC_OC_A: o_src.oc_a = 1'b1;
        SRC_OC_B: o_src.oc_b = 1'b1;
        SRC_TRIG: o_src.trig = 1'b1;
        default:  o_src = '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== ptssc_top_test.sv
// Self-checking bench of the stop/clear, sync clear, write disable, filter and buffer disable block
`timescale 1ns/100ps
`default_nettype none
module ptssc_top_test;
  import ptssc_pkg::*;
  localparam logic [3:0] CODES [9] = '{SRC_CMP0, SRC_CMP1, SRC_CMP2, SRC_CMP3, SRC_IO_A, SRC_IO_B,
                                       SRC_OC_A, SRC_OC_B, SRC_TRIG};
  logic             clk;
  logic             rst_n;
  logic             clk_en;
  ptssc_bus_req_t   bus;
  ptssc_src_in_t    src;
  logic [15:0]      rdata;
  logic [3:0]       stop;
  logic [3:0]       clr;
  logic [3:0]       wblk;
  logic [15:0]      bufd;
  logic             fire;
  logic [3:0]       code;
  logic [3:0]       len;
  int               fails = 0;
  int               checks = 0;
  int               cyc = 0;

  ptssc_top ptssc_top_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_bus(bus), .o_rdata(rdata),
    .i_src(src), .o_ch_stop(stop), .o_ch_clear(clr), .o_ch_write_block(wblk), .o_buf_disable(bufd));
  ptssc_src_model ptssc_src_model_i (.i_core_clk(clk), .i_fire(fire), .i_code(code), .i_len(len), .o_src(src));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails = fails + 1;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk(nm, e, rdata);
  endtask

  // Fire one source event and judge the stop and clear pulses over a fixed window
  task automatic ev(input logic [3:0] c, input logic [3:0] n, input logic [3:0] es, input logic [3:0] ec);
    logic [3:0] os;
    logic [3:0] oc;
    int         np;
    os = 4'h0;
    oc = 4'h0;
    np = 0;
    @(posedge clk);
    fire <= 1'b1;
    code <= c;
    len  <= n;
    @(posedge clk);
    fire <= 1'b0;
    repeat (16) begin
      @(posedge clk);
      #1;
      os = os | stop;
      oc = oc | clr;
      if ((stop | clr) !== 4'h0) np++;
    end
    chk("stop", {12'h000, es}, {12'h000, os});
    chk("clear", {12'h000, ec}, {12'h000, oc});
    chk("pulses", {15'h0000, |(es | ec)}, np[15:0]);
  endtask

  task automatic t_reset();
    rd_chk("selector", OFF_STOP_CLEAR_SOURCE_SELECT, RST_SRC_SEL);
    rd_chk("sync", OFF_SYNC_CLEAR_SELECT, RST_SYNC_SEL);
    rd_chk("filter", OFF_EXT_TRIGGER_FILTER_CTRL, 16'h0000);
    rd_chk("unmapped", 8'h20, 16'h0000);
    $display("reset test done");
  endtask

  task automatic t_codes();
    logic [15:0] sel;
    logic [15:0] en;
    logic [3:0]  e;
    for (int ch = 0; ch < 4; ch++) begin
      for (int i = 0; i < 9; i++) begin
        sel = 16'h0000;
        sel[ch*4 +: 4] = CODES[i];
        // Compare-output codes on channel 3 only while its hardware stop and clear enables are off
        en = (ch == 3 && (i == 6 || i == 7)) ? 16'h0000 : 16'h0101 << ch;
        e  = (en == 16'h0000) ? 4'h0 : 4'h1 << ch;
        wr(OFF_HW_STOP_CLEAR_ENABLE, en);
        wr(OFF_STOP_CLEAR_SOURCE_SELECT, sel);
        ev(CODES[i], 4'h3, e, e);
      end
      rd_chk("selector", OFF_STOP_CLEAR_SOURCE_SELECT, sel);
    end
    $display("source code test done");
  endtask

  task automatic t_sync();
    wr(OFF_STOP_CLEAR_SOURCE_SELECT, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_SYNC_CLEAR_SELECT, 16'h1111 * k);
      wr(OFF_HW_STOP_CLEAR_ENABLE, 16'h0101 << k);
      ev(SRC_CMP0, 4'h3, 4'h1 << k, 4'hF);
      wr(OFF_HW_STOP_CLEAR_ENABLE, 16'h0001 << k);
      ev(SRC_CMP0, 4'h3, 4'h1 << k, 4'h0);
    end
    wr(OFF_SYNC_CLEAR_SELECT, RST_SYNC_SEL);
    $display("sync clear test done");
  endtask

  task automatic t_wprot();
    wr(OFF_HW_STOP_CLEAR_ENABLE, 16'h0F0F);
    wr(OFF_CHANNEL_WRITE_DISABLE, 16'h0003);
    #1 chk("write block", 16'h0003, {12'h000, wblk});
    wr(OFF_HW_STOP_CLEAR_ENABLE, 16'h0000);
    rd_chk("enables", OFF_HW_STOP_CLEAR_ENABLE, 16'h0303);
    wr(OFF_CHANNEL_WRITE_DISABLE, 16'h0000);
    wr(OFF_HW_STOP_CLEAR_ENABLE, 16'h0000);
    rd_chk("enables", OFF_HW_STOP_CLEAR_ENABLE, 16'h0000);
    $display("write disable test done");
  endtask

  task automatic t_buf_filter();
    wr(OFF_BUFFER_DISABLE_CTRL, 16'hA5C3);
    #1 chk("buffer off", 16'hA5C3, bufd);
    rd_chk("buffer off", OFF_BUFFER_DISABLE_CTRL, 16'hA5C3);
    // Write with the clock enable low must be lost
    @(posedge clk);
    clk_en <= 1'b0;
    wr(OFF_BUFFER_DISABLE_CTRL, 16'h0000);
    @(posedge clk);
    clk_en <= 1'b1;
    #1 chk("buffer frozen", 16'hA5C3, bufd);
    wr(OFF_EXT_TRIGGER_FILTER_CTRL, 16'h00F3);
    rd_chk("filter", OFF_EXT_TRIGGER_FILTER_CTRL, 16'h0070);
    wr(OFF_EXT_TRIGGER_FILTER_CTRL, 16'h0040);
    wr(OFF_STOP_CLEAR_SOURCE_SELECT, {12'h000, SRC_TRIG});
    wr(OFF_HW_STOP_CLEAR_ENABLE, 16'h0101);
    ev(SRC_TRIG, 4'h2, 4'h0, 4'h0);
    ev(SRC_TRIG, 4'h8, 4'h1, 4'h1);
    $display("buffer and filter test done");
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    bus   = '0;
    fire  = 1'b0;
    code  = 4'h0;
    len   = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_codes();
    t_sync();
    t_wprot();
    t_buf_filter();
    finish_test();
  end
endmodule
`default_nettype wire
